// *** core/hlp_map.svh ***
// offsets, field positions, reset values and counts of the link protocoller
// assumes inclusion by bare name from core/ and verif/ files
`ifndef HLP_MAP_SVH
`define HLP_MAP_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define HLP_OFS_CTRL 4'h3
`define HLP_OFS_EVT 4'h4
`define HLP_OFS_QUEUE 4'h5

// ****************************************************************
// control and event bit positions
// ****************************************************************
`define HLP_CTL_RECEIVE_DISABLE 6
`define HLP_CTL_TRANSMIT_DISABLE 5
`define HLP_CTL_EOP 4
`define HLP_CTL_ABT 3
`define HLP_CTL_FILL 2
`define HLP_EV_GA 7
`define HLP_EV_END 6
`define HLP_EV_RDEND 5
`define HLP_EV_ABORT 4
`define HLP_EV_TXLOW 3
`define HLP_EV_UNDER 2
`define HLP_EV_RXTHR 1
`define HLP_EV_RXFULL 0

// ****************************************************************
// reset values, patterns and counts
// ****************************************************************
`define HLP_CTRL_RESET 8'h00
`define HLP_MASK_RESET 8'h00
`define HLP_FLAG 8'h7E
`define HLP_ONES 8'hFF
`define HLP_GA_PAT 9'h0FE
`define HLP_QDEPTH 4'hB
`define HLP_QMID 4'h4
`define HLP_RXTHR 4'h8
`define HLP_STUFF_RUN 5'h05
`define HLP_ABORT_RUN 5'h06
`define HLP_IDLE_RUN 5'h0E
`define HLP_MIN_BITS 12'h018
`define HLP_ABORT_BITS 12'h01A
`define HLP_GOOD_BITS 12'h020
`define HLP_CRC_POLY 16'h1021
`define HLP_CRC_INIT 16'hFFFF
`define HLP_CRC_RESIDUE 16'h1D0F
`define HLP_TAG_MID 2'h0
`define HLP_TAG_GOOD 2'h1
`define HLP_TAG_FIRST 2'h2
`define HLP_TAG_BAD 2'h3

`endif

// *** core/hlp_pkg.sv ***
// types shared by the link protocoller
// assumes the constants of hlp_map.svh
package hlp_pkg;

    typedef enum logic [5:0] {
        HLP_LINE  = 6'h01,
        HLP_OPEN  = 6'h02,
        HLP_DATA  = 6'h04,
        HLP_FCS   = 6'h08,
        HLP_CLOSE = 6'h10,
        HLP_ABORT = 6'h20
    } hlp_tx_state_e;

    typedef struct packed {
        logic [7:0] data;
        logic eop;
        logic abt;
    } hlp_tx_entry_s;

    typedef struct packed {
        logic [1:0] tag;
        logic [7:0] data;
    } hlp_rx_entry_s;

endpackage

// *** core/hlp_protocoller.sv ***
// link protocoller: framing, queues, event flags and register port
// assumes reg strobes from logic on clk_sys and a raw serial input pin
// Behaviour
// - status bit 7 reads one while any unmasked event flag is pending
// - idle status bit set while fifteen or more ones are received
// - received fill flags clear the idle status bit
// - two status bits tag the next receive byte: mid, good end, first, bad end
// - two status bits report transmit queue fill: full, four+, empty, three-
// - each mask bit lets its matching event flag raise the event request
// - received pattern 011111110 sets the go-ahead flag
// - packet end by flag, abort or invalid packet sets end-detected
// - reading a tagged end byte sets end-read
// - abort inside a packet of at least 26 bits sets frame-abort
// - transmit-low set when draining queue reaches three bytes
// - queue empty without end tag: eight ones, link state; underrun flag only after two or more bytes
// - receive-threshold set once receive queue holds eight bytes
// - receive-full set when full; further bytes dropped until read
// - reading event status clears all event flags
// - idle state sends ones; data ends the byte, then flag and data
// - fill state sends flags; current flag opens the packet
// - reset: transmitter idle and enabled, receiver enabled, events masked
// - end tag set before last byte; then checksum, closing flag
// - zero inserted after five ones in data and checksum
// - write to full transmit queue replaces the last byte
// - abort tag makes the byte an abort sequence; ignored under two bytes
// - seven or more ones inside a packet is a frame abort
// - disable bits force transmitted or received ones
// - checksum x16+x12+x5+1, complement sent msb first, checked on receive
`timescale 1ns/100ps
`include "hlp_map.svh"

module hlp_protocoller #(
    parameter int BIT_DIV = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // serial link
    input wire logic rx_pin,
    output logic tx_pin,
    // event request
    output logic event_req
);

    function automatic logic [3:0] qidx(input logic [3:0] b, input logic [3:0] o);
        logic [4:0] s;
        s = {1'b0, b} + {1'b0, o};
        if (s >= {1'b0, `HLP_QDEPTH}) s = s - {1'b0, `HLP_QDEPTH};
        return s[3:0];
    endfunction

    function automatic logic [1:0] fill_code(input logic [3:0] n);
        if (n == `HLP_QDEPTH) return 2'h0;
        if (n == 4'h0) return 2'h2;
        if (n >= `HLP_QMID) return 2'h1;
        return 2'h3;
    endfunction

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
        return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `HLP_CRC_POLY : 16'h0000);
    endfunction

    // ****************************************************************
    // registers and bit enable
    // ****************************************************************
    logic [7:0] ctrl, mask, ev, ev_set;
    logic [15:0] div;
    logic bit_en;
    logic wr_q, rd_q, rd_ev;
    hlp_pkg::hlp_rx_entry_s rq [0:10];
    logic [3:0] rq_rd, rq_cnt;
    logic [1:0] head_tag;

    assign wr_q = reg_wr && reg_addr == `HLP_OFS_QUEUE;
    assign rd_q = reg_rd && reg_addr == `HLP_OFS_QUEUE;
    assign rd_ev = reg_rd && reg_addr == `HLP_OFS_EVT;
    assign bit_en = div == 16'(BIT_DIV - 1);
    assign head_tag = rq[rq_rd].tag;

    always_ff @(posedge clk_sys) begin
        if (!resetn || bit_en) begin
            div <= 16'h0000;
        end else begin
            div <= div + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ctrl <= `HLP_CTRL_RESET;
            mask <= `HLP_MASK_RESET;
        end else if (reg_wr && reg_addr == `HLP_OFS_CTRL) begin
            ctrl <= reg_wdata;
        end else if (reg_wr && reg_addr == `HLP_OFS_EVT) begin
            mask <= reg_wdata;
        end else if (wr_q) begin
            ctrl[`HLP_CTL_EOP] <= 1'b0;
            ctrl[`HLP_CTL_ABT] <= 1'b0;
        end
    end

    // set wins over the clear on read
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ev <= 8'h00;
        end else begin
            ev <= (rd_ev ? 8'h00 : ev) | ev_set;
        end
    end

    assign event_req = |(ev & mask);

    logic idle;
    logic [3:0] tq_cnt;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `HLP_OFS_CTRL: reg_rdata <= {event_req, idle, head_tag,
                    fill_code(tq_cnt), fill_code(rq_cnt)};
                `HLP_OFS_EVT: reg_rdata <= ev;
                `HLP_OFS_QUEUE: reg_rdata <= rq[rq_rd].data;
                default: reg_rdata <= 8'hFF;
            endcase
        end
    end

    // ****************************************************************
    // transmit queue and framer
    // ****************************************************************
    hlp_pkg::hlp_tx_entry_s tq [0:10];
    hlp_pkg::hlp_tx_entry_s head;
    hlp_pkg::hlp_tx_state_e st, next_st;
    logic [3:0] tq_rd, pkt_n, ones;
    logic [15:0] sh, next_sh, crc, crc_fin;
    logic [4:0] left, next_left;
    logic tx_bit, tx_pop, ur, cur_eop, next_eop, stuffable, stuff_now, want_data, tx_full;

    assign head = tq[tq_rd];
    assign tx_full = tq_cnt == `HLP_QDEPTH && !tx_pop;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            tq_rd <= 4'h0;
            tq_cnt <= 4'h0;
        end else begin
            if (wr_q) begin
                tq[qidx(tq_rd, tx_full ? tq_cnt - 4'h1 : tq_cnt)] <= '{
                    data: reg_wdata, eop: ctrl[`HLP_CTL_EOP], abt: ctrl[`HLP_CTL_ABT]};
            end
            if (tx_pop) tq_rd <= qidx(tq_rd, 4'h1);
            if (wr_q && !tx_full && !tx_pop) tq_cnt <= tq_cnt + 4'h1;
            else if (tx_pop && !wr_q) tq_cnt <= tq_cnt - 4'h1;
        end
    end

    assign stuffable = st == hlp_pkg::HLP_DATA || st == hlp_pkg::HLP_FCS;
    // run count outlives the last checksum bit, so a zero still follows it
    assign stuff_now = {1'b0, ones} == `HLP_STUFF_RUN;
    assign crc_fin = st == hlp_pkg::HLP_DATA ? crc_step(crc, sh[0]) : crc;

    always_comb begin
        next_st = hlp_pkg::HLP_LINE;
        next_sh = {8'h00, ctrl[`HLP_CTL_FILL] ? `HLP_FLAG : `HLP_ONES};
        next_left = 5'h08;
        next_eop = 1'b0;
        want_data = 1'b0;
        tx_pop = 1'b0;
        ur = 1'b0;
        if (bit_en && !stuff_now && left == 5'h01) begin
            case (st)
                hlp_pkg::HLP_LINE: begin
                    if (tq_cnt != 4'h0) begin
                        if (ctrl[`HLP_CTL_FILL]) want_data = 1'b1;
                        else begin
                            next_st = hlp_pkg::HLP_OPEN;
                            next_sh = {8'h00, `HLP_FLAG};
                        end
                    end
                end
                hlp_pkg::HLP_OPEN: want_data = 1'b1;
                hlp_pkg::HLP_DATA: begin
                    if (cur_eop) begin
                        next_st = hlp_pkg::HLP_FCS;
                        next_sh = {<<{~crc_fin}};
                        next_left = 5'h10;
                    end else begin
                        want_data = 1'b1;
                    end
                end
                hlp_pkg::HLP_FCS: begin
                    next_st = hlp_pkg::HLP_CLOSE;
                    next_sh = {8'h00, `HLP_FLAG};
                end
                hlp_pkg::HLP_CLOSE: want_data = tq_cnt != 4'h0;
                hlp_pkg::HLP_ABORT: ;
                default: ;
            endcase
        end
        if (want_data) begin
            if (tq_cnt == 4'h0) begin
                next_st = hlp_pkg::HLP_ABORT;
                next_sh = {8'h00, `HLP_ONES};
                ur = pkt_n >= 4'h2;
            end else if (head.abt && pkt_n >= 4'h2) begin
                tx_pop = 1'b1;
                next_st = hlp_pkg::HLP_ABORT;
                next_sh = {8'h00, `HLP_ONES};
            end else begin
                tx_pop = 1'b1;
                next_st = hlp_pkg::HLP_DATA;
                next_sh = {8'h00, head.data};
                next_eop = head.eop;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            st <= hlp_pkg::HLP_LINE;
            sh <= {8'h00, `HLP_ONES};
            left <= 5'h08;
            ones <= 4'h0;
            tx_bit <= 1'b1;
            crc <= `HLP_CRC_INIT;
            pkt_n <= 4'h0;
            cur_eop <= 1'b0;
        end else if (bit_en) begin
            if (stuff_now) begin
                tx_bit <= 1'b0;
                ones <= 4'h0;
            end else begin
                tx_bit <= sh[0];
                ones <= (stuffable && sh[0]) ? ones + 4'h1 : 4'h0;
                crc <= crc_fin;
                if (left != 5'h01) begin
                    sh <= sh >> 1;
                    left <= left - 5'h01;
                end else begin
                    st <= next_st;
                    sh <= next_sh;
                    left <= next_left;
                    cur_eop <= next_eop;
                    if (next_st != hlp_pkg::HLP_DATA && next_st != hlp_pkg::HLP_FCS) begin
                        crc <= `HLP_CRC_INIT;
                        pkt_n <= 4'h0;
                    end else if (tx_pop && pkt_n != 4'hF) begin
                        pkt_n <= pkt_n + 4'h1;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) tx_pin <= 1'b1;
        else tx_pin <= ctrl[`HLP_CTL_TRANSMIT_DISABLE] | tx_bit;
    end

    // ****************************************************************
    // receive deframer and queue
    // ****************************************************************
    logic rx_s1, rx_s2, rbit, in_frame, first, drop, ga_hit, flag_hit, abt_hit, dbit;
    logic rx_push, rx_pop, rbyte_done;
    logic [8:0] hist;
    logic [4:0] rones;
    logic [6:0] dly;
    logic [2:0] dcnt, bcnt;
    logic [1:0] npend;
    logic [7:0] rbyte, pend0, pend1, pend2, next_byte;
    logic [11:0] nbits;
    logic [15:0] rcrc;
    hlp_pkg::hlp_rx_entry_s rx_push_e;

    always_ff @(posedge clk_sys) begin
        rx_s1 <= rx_pin;
        rx_s2 <= rx_s1;
    end

    assign rbit = ctrl[`HLP_CTL_RECEIVE_DISABLE] | rx_s2;
    assign ga_hit = {hist[7:0], rbit} == `HLP_GA_PAT;
    assign flag_hit = {hist[6:0], rbit} == `HLP_FLAG;
    assign abt_hit = in_frame && rbit && rones == `HLP_ABORT_RUN;
    assign dbit = !(rbit == 1'b0 && rones == `HLP_STUFF_RUN) && !flag_hit && !abt_hit;
    assign rbyte_done = dbit && in_frame && dcnt == 3'h7 && bcnt == 3'h7;
    assign next_byte = {dly[0], rbyte[7:1]};
    assign rx_pop = rd_q && rq_cnt != 4'h0;

    always_comb begin
        rx_push = 1'b0;
        rx_push_e = '{tag: first ? `HLP_TAG_FIRST : `HLP_TAG_MID, data: pend2};
        if (bit_en && in_frame && !drop) begin
            if (flag_hit && nbits >= `HLP_MIN_BITS && npend == 2'h3) begin
                rx_push = 1'b1;
                rx_push_e.tag = (nbits >= `HLP_GOOD_BITS && rcrc == `HLP_CRC_RESIDUE) ?
                    `HLP_TAG_GOOD : `HLP_TAG_BAD;
            end else if (abt_hit && nbits >= `HLP_MIN_BITS && npend != 2'h0) begin
                rx_push = 1'b1;
                rx_push_e = '{tag: `HLP_TAG_BAD, data: pend0};
            end else if (rbyte_done && npend == 2'h3) begin
                rx_push = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            hist <= 9'h000;
            rones <= 5'h00;
            idle <= 1'b0;
            in_frame <= 1'b0;
            dcnt <= 3'h0;
            bcnt <= 3'h0;
            npend <= 2'h0;
            nbits <= 12'h000;
            first <= 1'b0;
            drop <= 1'b0;
            rcrc <= `HLP_CRC_INIT;
        end else begin
            if (rx_pop) drop <= 1'b0;
            if (rx_push && rq_cnt == `HLP_QDEPTH && !rx_pop) drop <= 1'b1;
            if (rx_push) first <= 1'b0;
            if (bit_en) begin
                hist <= {hist[7:0], rbit};
                rones <= rbit ? rones + {4'h0, rones != 5'h1F} : 5'h00;
                if (rbit && rones >= `HLP_IDLE_RUN) idle <= 1'b1;
                if (flag_hit || abt_hit) begin
                    if (flag_hit) idle <= 1'b0;
                    in_frame <= flag_hit;
                    dcnt <= 3'h0;
                    bcnt <= 3'h0;
                    npend <= 2'h0;
                    nbits <= 12'h000;
                    first <= 1'b1;
                    drop <= 1'b0;
                    rcrc <= `HLP_CRC_INIT;
                end else if (dbit) begin
                    dly <= {rbit, dly[6:1]};
                    if (dcnt != 3'h7) begin
                        dcnt <= dcnt + 3'h1;
                    end else if (in_frame) begin
                        rbyte <= next_byte;
                        bcnt <= bcnt + 3'h1;
                        rcrc <= crc_step(rcrc, dly[0]);
                        if (nbits != 12'hFFF) nbits <= nbits + 12'h001;
                        if (bcnt == 3'h7) begin
                            pend0 <= next_byte;
                            pend1 <= pend0;
                            pend2 <= pend1;
                            if (npend != 2'h3) npend <= npend + 2'h1;
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            rq_rd <= 4'h0;
            rq_cnt <= 4'h0;
        end else begin
            if (rx_push && rq_cnt != `HLP_QDEPTH) rq[qidx(rq_rd, rq_cnt)] <= rx_push_e;
            if (rx_pop) rq_rd <= qidx(rq_rd, 4'h1);
            if (rx_push && rq_cnt != `HLP_QDEPTH && !rx_pop) rq_cnt <= rq_cnt + 4'h1;
            else if (rx_pop && !(rx_push && rq_cnt != `HLP_QDEPTH)) rq_cnt <= rq_cnt - 4'h1;
        end
    end

    // ****************************************************************
    // event sources
    // ****************************************************************
    always_comb begin
        ev_set = 8'h00;
        ev_set[`HLP_EV_GA] = bit_en && ga_hit;
        ev_set[`HLP_EV_END] = bit_en && in_frame && (flag_hit || abt_hit) && nbits != 12'h000;
        ev_set[`HLP_EV_RDEND] = rx_pop && head_tag[0];
        // one packet bit still sits in the delay line when the abort is seen
        ev_set[`HLP_EV_ABORT] = bit_en && abt_hit &&
            {1'b0, nbits} + 13'h0001 >= {1'b0, `HLP_ABORT_BITS};
        ev_set[`HLP_EV_TXLOW] = tx_pop && !wr_q && tq_cnt == `HLP_QMID;
        ev_set[`HLP_EV_UNDER] = ur;
        ev_set[`HLP_EV_RXTHR] = rx_push && !rx_pop && rq_cnt == `HLP_RXTHR - 4'h1;
        ev_set[`HLP_EV_RXFULL] = rx_push && !rx_pop && rq_cnt >= `HLP_QDEPTH - 4'h1;
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence s_five_ones;
        bit_en && stuff_now;
    endsequence
    sequence s_ev_read_quiet;
        rd_ev && ev_set == 8'h00;
    endsequence

    a_summary_bit: assert property (reg_rd && reg_addr == `HLP_OFS_CTRL
        |=> reg_rdata[7] == $past(event_req)) else $error("summary bit wrong");
    a_idle_set: assert property (bit_en && rbit && rones >= `HLP_IDLE_RUN
        |=> idle) else $error("idle not set");
    a_ga_flag: assert property (bit_en && ga_hit |=> ev[`HLP_EV_GA])
        else $error("go-ahead flag missing");
    a_event_clear: assert property (s_ev_read_quiet |=> ev == 8'h00)
        else $error("event flags not cleared");
    a_reset_masked: assert property (!$past(resetn) |-> mask == 8'h00
        && st == hlp_pkg::HLP_LINE && ctrl == 8'h00) else $error("reset state wrong");
    a_tx_stuffing: assert property (s_five_ones |=> !tx_bit)
        else $error("no inserted zero");
    a_tx_overwrite: assert property (wr_q && tx_full |=> tq_cnt == `HLP_QDEPTH)
        else $error("full queue grew");
    a_tx_low: assert property (tx_pop && !wr_q && tq_cnt == `HLP_QMID
        |=> ev[`HLP_EV_TXLOW] && tq_cnt == 4'h3) else $error("tx low missing");
    a_rx_full_drop: assert property (rx_push && rq_cnt == `HLP_QDEPTH && !rx_pop
        |=> rq_cnt == `HLP_QDEPTH && drop) else $error("full rx queue accepted");

endmodule

// *** verif/hlp_far_end.sv ***
// far-end model: transmission device that echoes the link back to the receiver
// assumes tx_pin and rx_pin of the protocoller, both on clk_sys
`timescale 1ns/100ps

module hlp_far_end (
    // clock
    input wire logic clk_sys,
    // serial link
    input wire logic tx_pin,
    output logic rx_pin,
    // control
    input wire logic loop_en
);
    // ****************************************************************
    // echo path
    // ****************************************************************
    logic echo;

    always_ff @(posedge clk_sys) begin
        echo <= tx_pin;
    end

    // a released line reads as ones, the idle level
    assign rx_pin = loop_en ? echo : 1'b1;
endmodule

// *** verif/tb_top.sv ***
// testbench: register port scenarios over a looped-back serial link
// assumes hlp_map.svh on the include path and the far end echoing tx to rx
`timescale 1ns/100ps
`include "hlp_map.svh"

module tb_top;
    // ****************************************************************
    // design, far end and clock
    // ****************************************************************
    localparam logic [3:0] AC = `HLP_OFS_CTRL;
    localparam logic [3:0] AE = `HLP_OFS_EVT;
    localparam logic [3:0] AQ = `HLP_OFS_QUEUE;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic rx_pin;
    logic tx_pin;
    logic event_req;
    logic loop_en = 1'b0;
    logic [7:0] d;
    int mismatches = 0;
    int n_tests = 0;

    always #25 clk_sys = ~clk_sys;

    hlp_protocoller #(.BIT_DIV(4)) hlp_protocoller_inst (.clk_sys(clk_sys), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .rx_pin(rx_pin), .tx_pin(tx_pin), .event_req(event_req));
    hlp_far_end hlp_far_end_inst (.clk_sys(clk_sys), .tx_pin(tx_pin), .rx_pin(rx_pin),
        .loop_en(loop_en));

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t %s: got %h want %h", $time, m, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        #1;
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_rd = 1'b0;
        v = reg_rdata;
    endtask

    task automatic wait_req(input int n);
        int i;
        i = 0;
        while (event_req !== 1'b1 && i < n) begin
            @(posedge clk_sys);
            #1;
            i++;
        end
        chk({7'h00, event_req}, 8'h01, "event request missing");
    endtask

    task automatic rxq(input logic [1:0] tag, input logic [7:0] v);
        logic [7:0] s;
        rd(AC, s);
        chk({6'h00, s[5:4]}, {6'h00, tag}, "receive byte tag");
        rd(AQ, s);
        chk(s, v, "receive byte data");
    endtask

    task automatic poll_idle(input logic want);
        int i;
        logic [7:0] s;
        i = 0;
        s = 8'h00;
        do begin
            rd(AC, s);
            i++;
        end while (s[6] !== want && i < 200);
        chk({7'h00, s[6]}, {7'h00, want}, "idle status");
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset();
        rd(AE, d);
        chk(d, 8'h00, "events after reset");
        rd(AC, d);
        chk({3'h0, d[7], d[3:0]}, 8'h0A, "status after reset");
        chk({7'h00, event_req}, 8'h00, "request after reset");
        $display("t_reset done");
    endtask

    task automatic t_packet();
        wr(AE, 8'h40);
        wr(AQ, 8'hFF);
        wr(AQ, 8'h7E);
        wr(AQ, 8'h00);
        wr(AC, 8'h10);
        wr(AQ, 8'h5A);
        wait_req(3000);
        rd(AC, d);
        chk({7'h00, d[7]}, 8'h01, "summary bit");
        rd(AE, d);
        chk(d & 8'h40, 8'h40, "end detected");
        rd(AE, d);
        chk(d, 8'h00, "clear on read");
        chk({7'h00, event_req}, 8'h00, "request cleared");
        rxq(2'h2, 8'hFF);
        rxq(2'h0, 8'h7E);
        rxq(2'h0, 8'h00);
        rxq(2'h1, 8'h5A);
        $display("t_packet done");
    endtask

    task automatic t_full();
        wr(AE, 8'h01);
        for (int i = 0; i < 11; i++) begin
            wr(AQ, 8'h10 + 8'(i));
            if (i == 3) begin
                rd(AC, d);
                chk({6'h00, d[3:2]}, 8'h01, "four or more");
            end
        end
        wr(AC, 8'h10);
        wr(AQ, 8'hC3);
        rd(AC, d);
        chk({6'h00, d[3:2]}, 8'h00, "transmit full");
        wait_req(8000);
        rd(AE, d);
        chk(d & 8'h0B, 8'h0B, "low, threshold, full");
        rd(AC, d);
        chk({6'h00, d[1:0]}, 8'h00, "receive full");
        rxq(2'h2, 8'h10);
        for (int i = 1; i < 10; i++) begin
            rxq(2'h0, 8'h10 + 8'(i));
        end
        rxq(2'h1, 8'hC3);
        chk({7'h00, event_req}, 8'h00, "masked end read");
        rd(AE, d);
        chk(d & 8'h20, 8'h20, "end byte read");
        $display("t_full done");
    endtask

    task automatic t_under();
        wr(AE, 8'h04);
        wr(AQ, 8'hA1);
        wr(AQ, 8'hA2);
        wait_req(3000);
        rd(AE, d);
        chk(d & 8'h04, 8'h04, "underrun");
        wr(AE, 8'h40);
        wait_req(3000);
        rd(AC, d);
        chk({6'h00, d[1:0]}, 8'h02, "short packet dropped");
        $display("t_under done");
    endtask

    task automatic t_idle();
        poll_idle(1'b1);
        wr(AC, 8'h04);
        poll_idle(1'b0);
        wr(AC, 8'h24);
        poll_idle(1'b1);
        wr(AC, 8'h04);
        poll_idle(1'b0);
        wr(AC, 8'h44);
        poll_idle(1'b1);
        wr(AC, 8'h04);
        poll_idle(1'b0);
        wr(AC, 8'h00);
        poll_idle(1'b1);
        $display("t_idle done");
    endtask

    task automatic t_abort();
        wr(AE, 8'h10);
        for (int i = 0; i < 4; i++) begin
            wr(AQ, 8'hB1 + 8'(i));
        end
        wr(AC, 8'h08);
        wr(AQ, 8'hEE);
        wait_req(3000);
        rd(AE, d);
        chk(d & 8'h10, 8'h10, "frame abort");
        $display("t_abort done");
    endtask

    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    initial begin
        repeat (20) @(posedge clk_sys);
        #1;
        resetn = 1'b1;
        loop_en = 1'b1;
        t_reset();
        t_packet();
        t_full();
        t_under();
        t_idle();
        t_abort();
        end_sim();
    end

    initial begin
        #2_000_000;
        mismatches++;
        $display("ERROR %0t watchdog expired", $time);
        end_sim();
    end
endmodule
